// *** rtl/preamp_serial_control_port.sv ***
// preamp serial control port: shift register, word latch, gain switching and flags
// Operation
// - one 16-bit word loaded serially sets gain and every support function
// - gain code gives unity or 9dB to 60dB in 3dB steps
// - servo-disable bit at 1 turns the output dc servo off
// - one word bit switches the input common-mode servo on or off
// - zero-cross enable defers new gain until an input zero crossing
// - deferred gain is applied at the latest after a 16ms timeout
// - over-range output high while output exceeds the selected threshold
// - threshold select 0 picks 5.1 Vrms, 1 picks 4.0 Vrms
// - four general outputs follow their word bits
// - serial data output allows cascading devices
// - chip select is active low
// - over-range output is active high
// - word is committed on the rising edge of chip select
// - data in sampled on rising clock, data out shifted on falling clock
// - chip select high ignores clock and data, data out is high impedance
`timescale 1ns/1ns
module preamp_serial_control_port #(
   parameter int ZC_TIMEOUT = preamp_pkg::ZC_TIMEOUT_CYC
) (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // serial port pins
   input wire logic cs_n_i,
   input wire logic sclk_i,
   input wire logic sdi_i,
   output logic sdo_o,
   output logic sdo_oe_o,
   // analog-side status
   input wire logic zero_cross_i,
   input wire logic above_5v1_i,
   input wire logic above_4v0_i,
   // applied settings
   output logic [5:0] gain_o,
   output logic servo_off_o,
   output logic cm_servo_on_o,
   output logic zc_enable_o,
   output logic over_range_flag_o,
   output logic general_output_one_o,
   output logic general_output_two_o,
   output logic general_output_three_o,
   output logic general_output_four_o
);
   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic [1:0] cs_s_r, sclk_s_r, sdi_s_r, zc_s_r, a51_s_r, a40_s_r;
   logic cs_d_r, sclk_d_r;
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cs_s_r <= 2'h3;
         sclk_s_r <= 2'h0;
         sdi_s_r <= 2'h0;
         zc_s_r <= 2'h0;
         a51_s_r <= 2'h0;
         a40_s_r <= 2'h0;
         cs_d_r <= 1'h1;
         sclk_d_r <= 1'h0;
      end else begin
         cs_s_r <= {cs_s_r[0], cs_n_i};
         sclk_s_r <= {sclk_s_r[0], sclk_i};
         sdi_s_r <= {sdi_s_r[0], sdi_i};
         zc_s_r <= {zc_s_r[0], zero_cross_i};
         a51_s_r <= {a51_s_r[0], above_5v1_i};
         a40_s_r <= {a40_s_r[0], above_4v0_i};
         cs_d_r <= cs_s_r[1];
         sclk_d_r <= sclk_s_r[1];
      end
   end

   logic selected, sclk_rise, sclk_fall, cs_rise;
   assign selected = !cs_s_r[1];
   assign sclk_rise = selected && sclk_s_r[1] && !sclk_d_r;
   assign sclk_fall = selected && !sclk_s_r[1] && sclk_d_r;
   assign cs_rise = cs_s_r[1] && !cs_d_r;

   // ----------------------------------------
   // shift register and data out
   // ----------------------------------------
   logic [15:0] shift_r;
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         shift_r <= preamp_pkg::WORD_RST;
      end else if (sclk_rise) begin
         shift_r <= {shift_r[14:0], sdi_s_r[1]};
      end
   end

   // msb leaves on the falling edge, so the chain sees the bit from 16 clocks back
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         sdo_o <= 1'h0;
         sdo_oe_o <= 1'h0;
      end else begin
         sdo_oe_o <= selected;
         if (sclk_fall) begin
            sdo_o <= shift_r[15];
         end
      end
   end

   // ----------------------------------------
   // word latch
   // ----------------------------------------
   preamp_pkg::settings_t set_r;
   logic new_gain_r;
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         set_r <= '0;
         new_gain_r <= 1'h0;
      end else begin
         new_gain_r <= 1'h0;
         if (cs_rise) begin
            set_r.gain <= shift_r[preamp_pkg::GAIN_LSB +: preamp_pkg::GAIN_BITS];
            set_r.servo_disable_bit <= shift_r[preamp_pkg::SERVO_DIS_POS];
            set_r.common_mode_servo_bit <= shift_r[preamp_pkg::CM_SERVO_POS];
            set_r.zero_cross_enable_bit <= shift_r[preamp_pkg::ZC_EN_POS];
            set_r.or_threshold_sel <= shift_r[preamp_pkg::OR_SEL_POS];
            set_r.general_outputs <= shift_r[preamp_pkg::GPO_LSB +: preamp_pkg::GPO_BITS];
            new_gain_r <= 1'h1;
         end
      end
   end

   // ----------------------------------------
   // gain switching
   // ----------------------------------------
   logic gain_ok;
   assign gain_ok = set_r.gain <= preamp_pkg::GAIN_MAX_CODE;
   logic pend_r;
   logic [5:0] pend_gain_r;
   logic [31:0] zc_cnt_r;
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         gain_o <= preamp_pkg::GAIN_RST;
         pend_r <= 1'h0;
         pend_gain_r <= preamp_pkg::GAIN_RST;
         zc_cnt_r <= '0;
      end else if (new_gain_r && gain_ok && set_r.gain != gain_o) begin
         if (set_r.zero_cross_enable_bit) begin
            pend_r <= 1'h1;
            pend_gain_r <= set_r.gain;
            zc_cnt_r <= '0;
         end else begin
            gain_o <= set_r.gain;
            pend_r <= 1'h0;
         end
      end else if (pend_r) begin
         if (zc_s_r[1] || zc_cnt_r >= 32'(ZC_TIMEOUT - 1)) begin
            gain_o <= pend_gain_r;
            pend_r <= 1'h0;
         end else begin
            zc_cnt_r <= zc_cnt_r + 32'h1;
         end
      end
   end

   // ----------------------------------------
   // control outputs and over-range
   // ----------------------------------------
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         servo_off_o <= 1'h0;
         cm_servo_on_o <= 1'h0;
         zc_enable_o <= 1'h0;
         over_range_flag_o <= 1'h0;
         general_output_one_o <= 1'h0;
         general_output_two_o <= 1'h0;
         general_output_three_o <= 1'h0;
         general_output_four_o <= 1'h0;
      end else begin
         servo_off_o <= set_r.servo_disable_bit;
         cm_servo_on_o <= set_r.common_mode_servo_bit;
         zc_enable_o <= set_r.zero_cross_enable_bit;
         over_range_flag_o <= set_r.or_threshold_sel ? a40_s_r[1] : a51_s_r[1];
         general_output_one_o <= set_r.general_outputs[0];
         general_output_two_o <= set_r.general_outputs[1];
         general_output_three_o <= set_r.general_outputs[2];
         general_output_four_o <= set_r.general_outputs[3];
      end
   end

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   sequence s_commit;
      cs_rise ##1 new_gain_r;
   endsequence

   a_word_servo_bit: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      s_commit |-> ##1 servo_off_o == set_r.servo_disable_bit)
      else $error("servo bit not applied");
   a_cm_bit: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      cs_rise |-> ##2 cm_servo_on_o == $past(shift_r[preamp_pkg::CM_SERVO_POS], 2))
      else $error("cm bit not applied");
   a_gpo_follow: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      cs_rise |-> ##2 general_output_four_o == $past(shift_r[preamp_pkg::GPO_LSB + 3], 2))
      else $error("gpo not applied");
   a_sdo_hiz: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      cs_s_r[1] |=> !sdo_oe_o)
      else $error("sdo driven while deselected");
   a_shift_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      cs_s_r[1] |=> $stable(shift_r))
      else $error("shift while deselected");
   a_shift_in: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      sclk_rise |=> shift_r[0] == $past(sdi_s_r[1]))
      else $error("sdi not shifted");
   a_sdo_msb: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      sclk_fall |=> sdo_o == $past(shift_r[15]))
      else $error("sdo not msb");
   a_gain_range: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      gain_o <= preamp_pkg::GAIN_MAX_CODE)
      else $error("illegal gain applied");
   a_gain_direct: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      new_gain_r && gain_ok && !set_r.zero_cross_enable_bit |=> gain_o == $past(set_r.gain))
      else $error("direct gain not applied");
   a_zc_timeout: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      zc_cnt_r < 32'(ZC_TIMEOUT))
      else $error("zero cross timeout overrun");
   a_ovr_sel: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      $stable(set_r.or_threshold_sel) |=>
      over_range_flag_o == $past(set_r.or_threshold_sel ? a40_s_r[1] : a51_s_r[1]))
      else $error("over-range threshold wrong");
endmodule

// *** include/preamp_pkg.sv ***
// package: control word layout, gain codes and timing for the preamp serial port
package preamp_pkg;
   localparam int WORD_BITS = 16;
   // field positions inside the control word
   localparam int GAIN_LSB = 0;
   localparam int GAIN_BITS = 6;
   localparam int SERVO_DIS_POS = 6;
   localparam int CM_SERVO_POS = 7;
   localparam int ZC_EN_POS = 8;
   localparam int OR_SEL_POS = 9;
   localparam int GPO_LSB = 10;
   localparam int GPO_BITS = 4;
   // gain codes: 0 unity, 1..18 = 9dB..60dB in 3dB steps
   localparam logic [5:0] GAIN_UNITY = 6'h00;
   localparam logic [5:0] GAIN_MAX_CODE = 6'h12;
   // reset values
   localparam logic [15:0] WORD_RST = 16'h0000;
   localparam logic [5:0] GAIN_RST = 6'h00;
   // zero-cross detector timeout
   localparam int CLK_HZ = 100_000_000;
   localparam int ZC_TIMEOUT_MS = 16;
   localparam int ZC_TIMEOUT_CYC = ZC_TIMEOUT_MS * (CLK_HZ / 1000);

   typedef struct packed {
      logic [5:0] gain;
      logic servo_disable_bit;
      logic common_mode_servo_bit;
      logic zero_cross_enable_bit;
      logic or_threshold_sel;
      logic [3:0] general_outputs;
   } settings_t;
endpackage

// *** sim/host_port_model.sv ***
// host serial port model that loads control words into the preamp port
`timescale 1ns/1ns
module host_port_model (
   // serial port pins
   output logic cs_n_o,
   output logic sclk_o,
   output logic sdi_o,
   input wire logic sdo_i
);
   initial begin
      cs_n_o = 1'b1;
      sclk_o = 1'b0;
      sdi_o = 1'b0;
   end
   // shifts n bits msb first and returns what the data output showed
   task automatic xfer(input logic [31:0] d, input int n, output logic [31:0] q);
      q = 32'h0;
      cs_n_o = 1'b0;
      #120;
      // 80 ns link period: data set at the fall, read back at the rise
      for (int i = n - 1; i >= 0; i--) begin
         sdi_o = d[i];
         #40;
         q[i] = sdo_i;
         sclk_o = 1'b1;
         #40 sclk_o = 1'b0;
      end
      #40 cs_n_o = 1'b1;
      // a released line must not keep showing the last bit
      sdi_o = ~sdi_o;
      #20;
   endtask
endmodule

// *** sim/tb_preamp_serial_control_port.sv ***
// testbench for the preamp serial control port
`timescale 1ns/1ns
module tb_preamp_serial_control_port;
   logic ref_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic zc_in = 1'b0;
   logic a5 = 1'b0;
   logic a4 = 1'b0;
   logic cs_n, sclk, sdi, sdo, sdo_oe, servo_off, cm_on, zc_en, over_range_flag, g1, g2, g3, g4;
   logic [5:0] gain;
   logic [31:0] q;
   logic [15:0] words [3] = '{16'h2892, 16'h1441, 16'hFCC0};
   int miscompares = 0;
   int tests_run = 0;
   wire [15:0] seen = {3'h0, g4, g3, g2, g1, zc_en, cm_on, servo_off, gain};
   // an undriven data out reads inverted, so a late or missing enable spoils readback
   wire sdo_line = sdo_oe ? sdo : ~sdo;

   always #5 ref_clk_i = ~ref_clk_i;

   host_port_model host_u (.cs_n_o(cs_n), .sclk_o(sclk), .sdi_o(sdi), .sdo_i(sdo_line));

   preamp_serial_control_port #(.ZC_TIMEOUT(20)) dut_u (
      .ref_clk_i(ref_clk_i), .rst_i(rst_i), .cs_n_i(cs_n), .sclk_i(sclk), .sdi_i(sdi),
      .sdo_o(sdo), .sdo_oe_o(sdo_oe), .zero_cross_i(zc_in), .above_5v1_i(a5),
      .above_4v0_i(a4), .gain_o(gain), .servo_off_o(servo_off), .cm_servo_on_o(cm_on),
      .zc_enable_o(zc_en), .over_range_flag_o(over_range_flag), .general_output_one_o(g1),
      .general_output_two_o(g2), .general_output_three_o(g3), .general_output_four_o(g4));

   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask

   // control outputs as they should look after a word; bit 9 only steers the flag
   function automatic logic [15:0] exp_of(input logic [15:0] w);
      return {3'h0, w[13:10], w[8:0]};
   endfunction

   task automatic wr(input logic [15:0] w);
      host_u.xfer({16'h0, w}, 16, q);
      repeat (6) @(negedge ref_clk_i);
   endtask

   task automatic results();
      $display("comparisons %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial begin
      #200000;
      miscompares++;
      results();
   end

   initial begin
      repeat (20) @(negedge ref_clk_i);
      rst_i = 1'b0;
      repeat (4) @(negedge ref_clk_i);
      chk("reset outputs", 16'h0000, seen);
      foreach (words[i]) begin
         wr(words[i]);
         chk("applied word", exp_of(words[i]), seen);
      end
      wr(16'h0053);
      chk("bad gain held", 16'h0040, seen);
      host_u.xfer({16'h0005, 16'h0200}, 32, q);
      chk("readback old word", 16'h0053, q[31:16]);
      chk("cascade output", 16'h0005, q[15:0]);
      repeat (6) @(negedge ref_clk_i);
      chk("data out released", 16'h0000, {15'h0, sdo_oe});
      a5 = 1'b1;
      repeat (5) @(negedge ref_clk_i);
      chk("flag low thr clear", 16'h0000, {15'h0, over_range_flag});
      a4 = 1'b1;
      repeat (5) @(negedge ref_clk_i);
      chk("flag low thr set", 16'h0001, {15'h0, over_range_flag});
      a5 = 1'b0;
      wr(16'h0000);
      chk("flag high thr clear", 16'h0000, {15'h0, over_range_flag});
      wr(16'h0100);
      wr(16'h010A);
      chk("gain deferred", 16'h0100, seen);
      zc_in = 1'b1;
      for (int k = 0; k < 6 && gain !== 6'h0A; k++)
         @(negedge ref_clk_i);
      zc_in = 1'b0;
      chk("gain on crossing", 16'h010A, seen);
      wr(16'h010C);
      chk("gain waits timeout", 16'h010A, seen);
      repeat (30) @(negedge ref_clk_i);
      chk("gain after timeout", 16'h010C, seen);
      results();
   end
endmodule
